/* common/cfp_pkg.sv */
// How it works
// - unmapped: user array code-read only, no writes
// - latch bit maps page buffer writes
// - latch bit beats eeprom mapping
// - space field picks user, extra row, security
// - launch needs nibble 5 then A
// - 5 does nothing, A commits by space
// - any instruction between keys aborts launch
// - busy flag high while programming runs
// - boot enable maps boot flash F800h-FFFFh
// - page buffer takes 1 to 128 bytes
// - erase then program only loaded bytes
// - last loaded page address picks target
// - launch honoured only from boot flash code
// - two lock bits give levels 1-3
// - lock bits parallel-only, default level 3
// - control layout: key, latch, space, busy
// - control register resets to zero
// - security upper nibble software, lower parallel
package cfp_pkg;
   // ----------------------------------------------------------
   // register map
   // ----------------------------------------------------------
   localparam logic [7:0] OFF_FCTRL = 8'h00;
   localparam logic [7:0] OFF_AUX = 8'h04;
   localparam logic [7:0] OFF_EECTRL = 8'h08;
   localparam logic [7:0] OFF_SEC = 8'h0C;
   localparam int FC_KEY_LSB = 4;
   localparam int FC_LATCH_BIT = 3;
   localparam int FC_SPACE_LSB = 1;
   localparam int FC_BUSY_BIT = 0;
   localparam int AUX_BOOT_BIT = 5;
   localparam int EE_MAP_BIT = 1;
   localparam int SEC_LEVEL_LSB = 8;
   localparam logic [7:0] FCTRL_RST = 8'h00;
   localparam logic [7:0] AUX_RST = 8'h00;
   localparam logic [7:0] EE_RST = 8'h00;
   localparam logic [7:0] SEC_RST = 8'hFD;
   // ----------------------------------------------------------
   // keys, spaces, address windows
   // ----------------------------------------------------------
   localparam logic [3:0] KEY_UNLOCK = 4'h5;
   localparam logic [3:0] KEY_LAUNCH = 4'hA;
   localparam logic [1:0] SPACE_USER = 2'b00;
   localparam logic [1:0] SPACE_XROW = 2'b01;
   localparam logic [1:0] SPACE_SEC = 2'b10;
   localparam logic [1:0] SPACE_RSVD = 2'b11;
   localparam logic [15:0] USER_TOP = 16'h3FFF;
   localparam logic [15:0] XROW_BASE = 16'hFF80;
   localparam logic [15:0] BOOT_BASE = 16'hF800;
   localparam logic [15:0] SEC_ADDR = 16'h0000;
   localparam int BYTE_W = 7;
   localparam logic [6:0] LAST_COL = 7'h7F;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;
   localparam logic [3:0] ERASED_NIB = 4'hF;
   localparam logic [7:0] BOOT_FILL = 8'h00;
   localparam logic [1:0] LEVEL_1 = 2'b01;
   localparam logic [1:0] LEVEL_2 = 2'b10;
   localparam logic [1:0] LEVEL_3 = 2'b11;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ERASE = 2'b01,
      ST_PROG = 2'b11,
      ST_DONE = 2'b10
   } cfp_state_e;
endpackage

/* verilog/cfp_cell_array.sv */
`timescale 1ns/1ps
// user pages plus the extra row as one flat byte store
module cfp_cell_array #(
   parameter int PAGES = 128,
   parameter int AW = 15
) (
   input wire logic clk,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_idx,
   input wire logic [7:0] wr_data,
   input wire logic [AW-1:0] rd_idx,
   output logic [7:0] rd_data
);
   localparam int DEPTH = (PAGES + 1) * 128;
   // nonvolatile cells: deliberately no reset
   logic [7:0] cells [DEPTH];
   logic [7:0] next_cell;

   always_comb begin
      next_cell = cells[wr_idx];
      if (wr_en) begin
         next_cell = wr_data;
      end
   end

   always_ff @(posedge clk) begin
      cells[wr_idx] <= next_cell;
   end

   assign rd_data = cells[rd_idx];
endmodule // cfp_cell_array

/* verilog/cfp_code_flash_ctrl.sv */
`timescale 1ns/1ps
module cfp_code_flash_ctrl #(
   parameter int PAGES = 128
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire logic code_rd_en,
   input wire logic [15:0] code_addr,
   output logic code_rd_valid,
   output logic [7:0] code_rd_data,
   output logic code_rd_boot,
   input wire logic data_wr_en,
   input wire logic [15:0] data_addr,
   input wire logic [7:0] data_wdata,
   output logic data_wr_eeprom,
   input wire logic other_instr,
   input wire logic exec_from_boot,
   input wire logic par_mode_pin,
   input wire logic par_lock_wr_pin,
   input wire logic [3:0] par_lock_data_pin,
   output logic prog_busy,
   output logic [1:0] prot_level,
   output logic par_prog_disable,
   output logic par_verify_disable,
   output logic ext_code_read_ok
);
   localparam int PG_W = $clog2(PAGES + 1);
   localparam int AW = PG_W + cfp_pkg::BYTE_W;

   function automatic logic [AW-1:0] cell_idx(
      input logic [PG_W-1:0] row,
      input logic [6:0] col
   );
      cell_idx = AW'({row, col});
   endfunction

   // lock bits: programmed reads as 0
   function automatic logic [1:0] level_of(input logic [2:0] lb);
      if (!lb[1]) begin
         level_of = cfp_pkg::LEVEL_3;
      end else if (!lb[0]) begin
         level_of = cfp_pkg::LEVEL_2;
      end else begin
         level_of = cfp_pkg::LEVEL_1;
      end
   endfunction

   // ----------------------------------------------------------
   // apb slave and software registers
   // ----------------------------------------------------------
   logic [3:0] key;
   logic latch_map_bit;
   logic [1:0] space_select_field;
   logic boot_space_enable;
   logic eeprom_map_bit;
   logic unlocked;
   logic [7:0] sec_byte;
   logic [3:0] next_key;
   logic next_latch_map;
   logic [1:0] next_space;
   logic next_boot_en;
   logic next_ee_map;
   logic next_unlocked;
   logic next_pready;
   logic [31:0] next_prdata;
   logic next_pslverr;
   logic commit;
   logic fc_wr;
   logic launch;
   logic [7:0] fc_read;

   always_comb begin
      commit = psel & penable & pready & ~pslverr;
      fc_wr = commit & pwrite & (paddr == cfp_pkg::OFF_FCTRL) & ~prog_busy;
      fc_read = {key, latch_map_bit, space_select_field, prog_busy};
      next_pready = psel & penable & ~pready;
      next_pslverr = 1'b0;
      next_prdata = prdata;
      if (psel & penable & ~pready) begin
         next_prdata = '0;
         case (paddr)
            cfp_pkg::OFF_FCTRL: next_prdata[7:0] = fc_read;
            cfp_pkg::OFF_AUX:
               next_prdata[cfp_pkg::AUX_BOOT_BIT] = boot_space_enable;
            cfp_pkg::OFF_EECTRL:
               next_prdata[cfp_pkg::EE_MAP_BIT] = eeprom_map_bit;
            cfp_pkg::OFF_SEC: begin
               next_prdata[7:0] = sec_byte;
               next_prdata[cfp_pkg::SEC_LEVEL_LSB +: 2] = prot_level;
            end
            default: next_pslverr = 1'b1;
         endcase
      end
      next_key = key;
      next_latch_map = latch_map_bit;
      next_space = space_select_field;
      if (fc_wr) begin
         // busy bit position is dropped on purpose
         next_key = pwdata[cfp_pkg::FC_KEY_LSB +: 4];
         next_latch_map = pwdata[cfp_pkg::FC_LATCH_BIT];
         next_space = pwdata[cfp_pkg::FC_SPACE_LSB +: 2];
      end
      next_boot_en = boot_space_enable;
      if (commit & pwrite & (paddr == cfp_pkg::OFF_AUX)) begin
         next_boot_en = pwdata[cfp_pkg::AUX_BOOT_BIT];
      end
      next_ee_map = eeprom_map_bit;
      if (commit & pwrite & (paddr == cfp_pkg::OFF_EECTRL)) begin
         next_ee_map = pwdata[cfp_pkg::EE_MAP_BIT];
      end
      // key sequence: 5 arms, A fires, anything else disarms
      next_unlocked = unlocked;
      if (other_instr) begin
         next_unlocked = 1'b0;
      end
      if (fc_wr) begin
         next_unlocked = (next_key == cfp_pkg::KEY_UNLOCK);
      end
      // launching from user flash is refused silently
      launch = fc_wr & unlocked & exec_from_boot
         & (next_key == cfp_pkg::KEY_LAUNCH)
         & (next_space != cfp_pkg::SPACE_RSVD);
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
         key <= cfp_pkg::FCTRL_RST[7:4];
         latch_map_bit <= cfp_pkg::FCTRL_RST[cfp_pkg::FC_LATCH_BIT];
         space_select_field <= cfp_pkg::FCTRL_RST[2:1];
         boot_space_enable <= cfp_pkg::AUX_RST[cfp_pkg::AUX_BOOT_BIT];
         eeprom_map_bit <= cfp_pkg::EE_RST[cfp_pkg::EE_MAP_BIT];
         unlocked <= 1'b0;
      end else begin
         pready <= next_pready;
         pslverr <= next_pslverr;
         prdata <= next_prdata;
         key <= next_key;
         latch_map_bit <= next_latch_map;
         space_select_field <= next_space;
         boot_space_enable <= next_boot_en;
         eeprom_map_bit <= next_ee_map;
         unlocked <= next_unlocked;
      end
   end

   // ----------------------------------------------------------
   // page buffer
   // ----------------------------------------------------------
   cfp_pkg::cfp_state_e state;
   logic [7:0] latch_data [128];
   logic [127:0] loaded;
   logic [PG_W-1:0] page;
   logic [7:0] next_latch_data [128];
   logic [127:0] next_loaded;
   logic [PG_W-1:0] next_page;
   logic next_ee_route;
   logic in_user;
   logic in_xrow;
   logic load;

   always_comb begin
      in_user = data_addr <= cfp_pkg::USER_TOP;
      in_xrow = (space_select_field == cfp_pkg::SPACE_XROW)
         & (data_addr >= cfp_pkg::XROW_BASE);
      // data writes never reach the array directly
      load = data_wr_en & latch_map_bit & (in_user | in_xrow)
         & ~prog_busy;
      next_latch_data = latch_data;
      next_loaded = loaded;
      next_page = page;
      if (load) begin
         next_latch_data[data_addr[6:0]] = data_wdata;
         next_loaded[data_addr[6:0]] = 1'b1;
         if (in_user) begin
            next_page = PG_W'(data_addr[14:7]);
         end
      end
      if (state == cfp_pkg::ST_DONE) begin
         next_loaded = '0;
      end
      // latch map shadows the eeprom mapping
      next_ee_route = data_wr_en & eeprom_map_bit & ~latch_map_bit;
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < 128; i++) begin
            latch_data[i] <= cfp_pkg::ERASED_BYTE;
         end
         loaded <= '0;
         page <= '0;
         data_wr_eeprom <= 1'b0;
      end else begin
         latch_data <= next_latch_data;
         loaded <= next_loaded;
         page <= next_page;
         data_wr_eeprom <= next_ee_route;
      end
   end

   // ----------------------------------------------------------
   // erase-then-program sequencer
   // ----------------------------------------------------------
   cfp_pkg::cfp_state_e next_state;
   logic [1:0] tgt_space;
   logic [6:0] col;
   logic [1:0] next_tgt;
   logic [6:0] next_col;
   logic next_busy;
   logic [7:0] next_sec;
   logic arr_wr;
   logic [AW-1:0] arr_wr_idx;
   logic [7:0] arr_wr_data;
   logic [PG_W-1:0] tgt_row;
   logic [2:0] par_mode_s;
   logic [2:0] par_wr_s;
   logic [3:0] par_data_s1;
   logic [3:0] par_data_s2;
   logic par_lock_wr;

   always_comb begin
      next_state = state;
      next_tgt = tgt_space;
      next_col = col;
      next_sec = sec_byte;
      arr_wr = 1'b0;
      arr_wr_data = cfp_pkg::ERASED_BYTE;
      tgt_row = (tgt_space == cfp_pkg::SPACE_XROW) ? PG_W'(PAGES) : page;
      arr_wr_idx = cell_idx(tgt_row, col);
      case (state)
         cfp_pkg::ST_IDLE: begin
            if (launch) begin
               next_state = cfp_pkg::ST_ERASE;
               next_tgt = next_space;
               next_col = '0;
            end
         end
         cfp_pkg::ST_ERASE: begin
            // only loaded cells are erased
            if (tgt_space == cfp_pkg::SPACE_SEC) begin
               if (col == '0 && loaded[0]) begin
                  next_sec[7:4] = cfp_pkg::ERASED_NIB;
               end
            end else begin
               arr_wr = loaded[col];
            end
            next_col = col + 7'h01;
            if (col == cfp_pkg::LAST_COL) begin
               next_state = cfp_pkg::ST_PROG;
            end
         end
         cfp_pkg::ST_PROG: begin
            arr_wr_data = latch_data[col];
            if (tgt_space == cfp_pkg::SPACE_SEC) begin
               // low nibble stays out of software reach
               if (col == '0 && loaded[0]) begin
                  next_sec[7:4] = latch_data[0][7:4];
               end
            end else begin
               arr_wr = loaded[col];
            end
            next_col = col + 7'h01;
            if (col == cfp_pkg::LAST_COL) begin
               next_state = cfp_pkg::ST_DONE;
            end
         end
         cfp_pkg::ST_DONE: next_state = cfp_pkg::ST_IDLE;
         default: next_state = cfp_pkg::ST_IDLE;
      endcase
      next_busy = next_state != cfp_pkg::ST_IDLE;
      par_lock_wr = par_wr_s[1] & ~par_wr_s[2] & par_mode_s[1];
      if (par_lock_wr) begin
         next_sec[3:0] = par_data_s2;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= cfp_pkg::ST_IDLE;
         tgt_space <= cfp_pkg::SPACE_USER;
         col <= '0;
         prog_busy <= 1'b0;
         sec_byte <= cfp_pkg::SEC_RST;
         par_mode_s <= '0;
         par_wr_s <= '0;
         par_data_s1 <= '0;
         par_data_s2 <= '0;
      end else begin
         state <= next_state;
         tgt_space <= next_tgt;
         col <= next_col;
         prog_busy <= next_busy;
         sec_byte <= next_sec;
         par_mode_s <= {par_mode_s[1:0], par_mode_pin};
         par_wr_s <= {par_wr_s[1:0], par_lock_wr_pin};
         par_data_s1 <= par_lock_data_pin;
         par_data_s2 <= par_data_s1;
      end
   end

   // ----------------------------------------------------------
   // code-space read mapping and protection level
   // ----------------------------------------------------------
   logic [AW-1:0] rd_idx;
   logic [7:0] arr_rd_data;
   logic [7:0] next_rd_data;
   logic next_rd_boot;
   logic [1:0] next_level;
   logic xrow_hit;

   always_comb begin
      rd_idx = cell_idx(PG_W'(code_addr[14:7]), code_addr[6:0]);
      next_rd_data = cfp_pkg::ERASED_BYTE;
      next_rd_boot = 1'b0;
      xrow_hit = (space_select_field == cfp_pkg::SPACE_XROW)
         & (code_addr >= cfp_pkg::XROW_BASE);
      // extra row mapping wins over the boot window overlap
      if (boot_space_enable & (code_addr >= cfp_pkg::BOOT_BASE)
         & ~xrow_hit) begin
         next_rd_boot = 1'b1;
         next_rd_data = cfp_pkg::BOOT_FILL;
      end else begin
         case (space_select_field)
            cfp_pkg::SPACE_USER: begin
               if (code_addr <= cfp_pkg::USER_TOP) begin
                  next_rd_data = arr_rd_data;
               end
            end
            cfp_pkg::SPACE_XROW: begin
               rd_idx = cell_idx(PG_W'(PAGES), code_addr[6:0]);
               if (xrow_hit) begin
                  next_rd_data = arr_rd_data;
               end
            end
            cfp_pkg::SPACE_SEC: begin
               if (code_addr == cfp_pkg::SEC_ADDR) begin
                  next_rd_data = sec_byte;
               end
            end
            default: next_rd_data = cfp_pkg::ERASED_BYTE;
         endcase
      end
      next_level = level_of(sec_byte[2:0]);
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         code_rd_valid <= 1'b0;
         code_rd_data <= '0;
         code_rd_boot <= 1'b0;
         prot_level <= cfp_pkg::LEVEL_3;
         par_prog_disable <= 1'b1;
         par_verify_disable <= 1'b1;
         ext_code_read_ok <= 1'b0;
      end else begin
         code_rd_valid <= code_rd_en;
         code_rd_data <= code_rd_en ? next_rd_data : code_rd_data;
         code_rd_boot <= code_rd_en & next_rd_boot;
         prot_level <= next_level;
         par_prog_disable <= next_level != cfp_pkg::LEVEL_1;
         par_verify_disable <= next_level == cfp_pkg::LEVEL_3;
         ext_code_read_ok <= next_level == cfp_pkg::LEVEL_1;
      end
   end

   cfp_cell_array #(
      .PAGES(PAGES),
      .AW(AW)
   ) u_cells (
      .clk(clk),
      .wr_en(arr_wr),
      .wr_idx(arr_wr_idx),
      .wr_data(arr_wr_data),
      .rd_idx(rd_idx),
      .rd_data(arr_rd_data)
   );
endmodule // cfp_code_flash_ctrl

/* test/cfp_assertions.sv */
`timescale 1ns/1ps
module cfp_checker (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   input wire logic code_rd_en,
   input wire logic [15:0] code_addr,
   input wire logic code_rd_valid,
   input wire logic [7:0] code_rd_data,
   input wire logic code_rd_boot,
   input wire logic data_wr_en,
   input wire logic data_wr_eeprom,
   input wire logic prog_busy,
   input wire logic [1:0] prot_level,
   input wire logic par_prog_disable,
   input wire logic par_verify_disable,
   input wire logic ext_code_read_ok
);
   // ------------------------------
   // helper logic
   // ------------------------------
   localparam int BUSY_SPAN = 257;
   logic [8:0] busy_cnt;
   logic [8:0] next_busy_cnt;
   logic launch_wr;
   assign launch_wr = psel && penable && pready && pwrite
      && paddr == cfp_pkg::OFF_FCTRL
      && pwdata[7:4] == cfp_pkg::KEY_LAUNCH;
   always_comb begin
      next_busy_cnt = prog_busy ? busy_cnt + 9'd1 : 9'd0;
   end
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         busy_cnt <= 9'd0;
      end else begin
         busy_cnt <= next_busy_cnt;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence s_first_access;
      psel && penable && !pready;
   endsequence
   sequence s_busy_rise;
      !prog_busy ##1 prog_busy;
   endsequence
   // ------------------------------
   // assertions
   // ------------------------------
   AST_APB_WAIT: assert property (s_first_access |=> pready)
      else $error("pready late");
   AST_APB_PULSE: assert property (pready |=> !pready)
      else $error("pready held");
   AST_ERR_ZERO: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("bad error answer");
   AST_CODE_RD: assert property (code_rd_en |=> code_rd_valid)
      else $error("code read unanswered");
   AST_CODE_IDLE: assert property (!code_rd_en |=> !code_rd_valid)
      else $error("spurious code read");
   AST_BOOT_WIN: assert property (code_rd_boot |-> code_rd_valid
      && $past(code_addr) >= cfp_pkg::BOOT_BASE
      && code_rd_data == cfp_pkg::BOOT_FILL)
      else $error("boot window wrong");
   AST_BUSY_CAUSE: assert property (s_busy_rise |-> $past(launch_wr))
      else $error("busy without launch");
   AST_BUSY_SPAN: assert property ($fell(prog_busy) |-> busy_cnt == BUSY_SPAN)
      else $error("busy span wrong");
   AST_EE_CAUSE: assert property (data_wr_eeprom |-> $past(data_wr_en))
      else $error("eeprom write uncaused");
   AST_LEVEL_MAP: assert property (prot_level != 2'b00
      && par_prog_disable == (prot_level != cfp_pkg::LEVEL_1)
      && par_verify_disable == (prot_level == cfp_pkg::LEVEL_3)
      && ext_code_read_ok == (prot_level == cfp_pkg::LEVEL_1))
      else $error("protection outputs wrong");
endmodule // cfp_checker

bind cfp_code_flash_ctrl cfp_checker u_chk (
   .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .prdata(prdata), .pslverr(pslverr), .code_rd_en(code_rd_en),
   .code_addr(code_addr), .code_rd_valid(code_rd_valid),
   .code_rd_data(code_rd_data), .code_rd_boot(code_rd_boot),
   .data_wr_en(data_wr_en), .data_wr_eeprom(data_wr_eeprom),
   .prog_busy(prog_busy), .prot_level(prot_level),
   .par_prog_disable(par_prog_disable),
   .par_verify_disable(par_verify_disable),
   .ext_code_read_ok(ext_code_read_ok)
);

/* test/cfp_core_model.sv */
`timescale 1ns/1ps
// no interrupt source modelled, so none can break programming
module cfp_core_model (
   input wire logic clk,
   input wire logic code_rd_valid,
   input wire logic [7:0] code_rd_data,
   input wire logic code_rd_boot,
   input wire logic data_wr_eeprom,
   output logic code_rd_en,
   output logic [15:0] code_addr,
   output logic data_wr_en,
   output logic [15:0] data_addr,
   output logic [7:0] data_wdata,
   output logic other_instr,
   output logic exec_from_boot
);
   initial begin
      code_rd_en = 1'b0;
      code_addr = 16'h0000;
      data_wr_en = 1'b0;
      data_addr = 16'h0000;
      data_wdata = 8'h00;
      other_instr = 1'b0;
      exec_from_boot = 1'b0;
   end
   // idle address lines flip so stale values never look valid
   task code_read(input logic [15:0] a, output logic [7:0] d,
      output logic b);
      @(posedge clk);
      code_rd_en <= 1'b1;
      code_addr <= a;
      @(posedge clk);
      code_rd_en <= 1'b0;
      code_addr <= ~a;
      @(posedge clk);
      d = (code_rd_valid === 1'b1) ? code_rd_data : 8'hxx;
      b = code_rd_boot;
   endtask
   task data_write(input logic [15:0] a, input logic [7:0] v,
      output logic e);
      @(posedge clk);
      data_wr_en <= 1'b1;
      data_addr <= a;
      data_wdata <= v;
      @(posedge clk);
      data_wr_en <= 1'b0;
      data_addr <= ~a;
      data_wdata <= ~v;
      @(posedge clk);
      e = data_wr_eeprom;
   endtask
   // an instruction between unlock and launch
   task pulse_other();
      @(posedge clk);
      other_instr <= 1'b1;
      @(posedge clk);
      other_instr <= 1'b0;
   endtask
endmodule // cfp_core_model

/* test/tb.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
   $display("Error t=%0t got %h exp %h", $time, g, e); end end
module tb;
   logic clk, sys_rst, psel, penable, pwrite, pready, pslverr, prog_busy;
   logic [7:0] paddr, code_rd_data, data_wdata;
   logic [31:0] pwdata, prdata;
   logic [15:0] code_addr, data_addr;
   logic code_rd_en, code_rd_valid, code_rd_boot, data_wr_en, data_wr_eeprom;
   logic other_instr, exec_from_boot, par_mode_pin, par_lock_wr_pin;
   logic [3:0] par_lock_data_pin;
   logic [1:0] prot_level;
   logic par_prog_disable, par_verify_disable, ext_code_read_ok;
   int errors, cmp_count;
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   cfp_code_flash_ctrl #(.PAGES(128)) dut (.clk(clk), .sys_rst(sys_rst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .code_rd_en(code_rd_en), .code_addr(code_addr),
      .code_rd_valid(code_rd_valid), .code_rd_data(code_rd_data),
      .code_rd_boot(code_rd_boot), .data_wr_en(data_wr_en),
      .data_addr(data_addr), .data_wdata(data_wdata),
      .data_wr_eeprom(data_wr_eeprom), .other_instr(other_instr),
      .exec_from_boot(exec_from_boot), .par_mode_pin(par_mode_pin),
      .par_lock_wr_pin(par_lock_wr_pin), .par_lock_data_pin(par_lock_data_pin),
      .prog_busy(prog_busy), .prot_level(prot_level),
      .par_prog_disable(par_prog_disable),
      .par_verify_disable(par_verify_disable),
      .ext_code_read_ok(ext_code_read_ok));
   cfp_core_model core (.clk(clk), .code_rd_valid(code_rd_valid),
      .code_rd_data(code_rd_data), .code_rd_boot(code_rd_boot),
      .data_wr_eeprom(data_wr_eeprom), .code_rd_en(code_rd_en),
      .code_addr(code_addr), .data_wr_en(data_wr_en), .data_addr(data_addr),
      .data_wdata(data_wdata), .other_instr(other_instr),
      .exec_from_boot(exec_from_boot));
   // ------------------------------
   // access tasks
   // ------------------------------
   task finish_test();
      if (errors == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) errors++;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      xfer(1'b1, a, d, r, e);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
      logic [31:0] r;
      logic e;
      xfer(1'b0, a, 32'h0000_0000, r, e);
      `CHK(r, x)
      `CHK(e, xe)
   endtask
   task cr(input logic [15:0] a, input logic [7:0] x, input logic xb);
      logic [7:0] d;
      logic b;
      core.code_read(a, d, b);
      `CHK(d, x)
      `CHK(b, xb)
   endtask
   task dw(input logic [15:0] a, input logic [7:0] v, input logic xe);
      logic e;
      core.data_write(a, v, e);
      `CHK(e, xe)
   endtask
   // mode 0: launch key alone, 1: unlock first, 2: instruction between
   task launch(input logic [1:0] sp, input logic go, input int mode);
      int n;
      if (mode != 0) wr(8'h00, {24'h0, 4'h5, 1'b0, sp, 1'b0});
      if (mode == 2) core.pulse_other();
      wr(8'h00, {24'h0, 4'hA, 1'b0, sp, 1'b0});
      repeat (2) @(posedge clk);
      `CHK(prog_busy, go)
      n = 0;
      while (prog_busy !== 1'b0 && n < 400) begin
         @(posedge clk);
         n++;
      end
      `CHK(prog_busy, 1'b0)
   endtask
   // pin is synced, so hold it a few cycles
   task lock(input logic [3:0] v);
      par_lock_data_pin <= v;
      par_lock_wr_pin <= 1'b1;
      repeat (4) @(posedge clk);
      par_lock_wr_pin <= 1'b0;
      repeat (6) @(posedge clk);
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      finish_test();
   end
   initial begin
      {sys_rst, psel, penable, pwrite, paddr, pwdata} = {4'b1000, 40'h0};
      {par_mode_pin, par_lock_wr_pin, par_lock_data_pin} = 6'h00;
      errors = 0;
      cmp_count = 0;
      repeat (4) @(posedge clk);
      sys_rst <= 1'b0;
      rd(8'h00, 32'h0000_0000, 1'b0);
      rd(8'h0C, 32'h0000_03FD, 1'b0);
      `CHK({par_prog_disable, par_verify_disable, ext_code_read_ok}, 3'b110)
      rd(8'h10, 32'h0000_0000, 1'b1);
      wr(8'h00, 32'h0000_000F);
      rd(8'h00, 32'h0000_000E, 1'b0);
      core.exec_from_boot <= 1'b1;
      wr(8'h00, 32'h0000_0008);
      dw(16'h0100, 8'h00, 1'b0);
      dw(16'h0102, 8'h77, 1'b0);
      launch(2'b00, 1'b1, 1);
      wr(8'h00, 32'h0000_0008);
      dw(16'h0080, 8'h11, 1'b0);
      dw(16'h0101, 8'h22, 1'b0);
      dw(16'h017F, 8'h3C, 1'b0);
      launch(2'b00, 1'b1, 1);
      cr(16'h0100, 8'h11, 1'b0);
      cr(16'h0101, 8'h22, 1'b0);
      cr(16'h0102, 8'h77, 1'b0);
      cr(16'h017F, 8'h3C, 1'b0);
      dw(16'h0101, 8'h99, 1'b0);
      cr(16'h0101, 8'h22, 1'b0);
      wr(8'h00, 32'h0000_0008);
      dw(16'h0100, 8'h55, 1'b0);
      launch(2'b00, 1'b0, 2);
      launch(2'b00, 1'b0, 0);
      core.exec_from_boot <= 1'b0;
      launch(2'b00, 1'b0, 1);
      core.exec_from_boot <= 1'b1;
      launch(2'b11, 1'b0, 1);
      launch(2'b00, 1'b1, 1);
      cr(16'h0100, 8'h55, 1'b0);
      wr(8'h00, 32'h0000_000A);
      dw(16'hFF80, 8'h5A, 1'b0);
      dw(16'hFFFF, 8'hC3, 1'b0);
      launch(2'b01, 1'b1, 1);
      wr(8'h00, 32'h0000_0002);
      cr(16'hFF80, 8'h5A, 1'b0);
      cr(16'hFFFF, 8'hC3, 1'b0);
      wr(8'h00, 32'h0000_000C);
      dw(16'h0000, 8'h3A, 1'b0);
      launch(2'b10, 1'b1, 1);
      rd(8'h0C, 32'h0000_033D, 1'b0);
      wr(8'h00, 32'h0000_0004);
      cr(16'h0000, 8'h3D, 1'b0);
      wr(8'h00, 32'h0000_0000);
      par_mode_pin <= 1'b1;
      lock(4'hE);
      `CHK({par_prog_disable, par_verify_disable, ext_code_read_ok}, 3'b100)
      rd(8'h0C, 32'h0000_023E, 1'b0);
      lock(4'hF);
      `CHK({par_prog_disable, par_verify_disable, ext_code_read_ok}, 3'b001)
      rd(8'h0C, 32'h0000_013F, 1'b0);
      wr(8'h08, 32'h0000_0002);
      dw(16'h0200, 8'h00, 1'b1);
      wr(8'h00, 32'h0000_0008);
      dw(16'h0200, 8'h00, 1'b0);
      wr(8'h00, 32'h0000_0000);
      wr(8'h08, 32'h0000_0000);
      wr(8'h04, 32'h0000_0020);
      cr(16'hF800, 8'h00, 1'b1);
      cr(16'hF7FF, 8'hFF, 1'b0);
      rd(8'h04, 32'h0000_0020, 1'b0);
      wr(8'h00, 32'h0000_000E);
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      rd(8'h00, 32'h0000_0000, 1'b0);
      finish_test();
   end
endmodule // tb
